// File: pkg/dwp_pkg.sv
// package with field layout, command codes and timing of the serial port
package dwp_pkg;
  // frame geometry
  localparam int          CODE_W       = 8;            // wiper code width, 256 taps
  localparam int          CNT_W        = 5;            // edge counter width
  localparam logic [4:0]  EDGES_LONG   = 5'h10;        // write or long copy frame
  localparam logic [4:0]  EDGES_SHORT  = 5'h08;        // short copy frame
  localparam logic [4:0]  EDGES_MAX    = 5'h1F;        // counter saturates here
  // header byte field positions
  localparam int          HDR_CMD_HI   = 5;            // command_bit_high
  localparam int          HDR_CMD_LO   = 4;            // command_bit_low
  localparam int          HDR_SEL_HI   = 1;            // select_bit_high
  localparam int          HDR_SEL_LO   = 0;            // select_bit_low
  // command codes
  localparam logic [1:0]  CMD_WR_WIPER = 2'h0;         // load wiper register
  localparam logic [1:0]  CMD_WR_STORE = 2'h1;         // load stored register
  localparam logic [1:0]  CMD_CP_STORE = 2'h2;         // wiper to stored copy
  localparam logic [1:0]  CMD_CP_WIPER = 2'h3;         // stored to wiper copy
  // select codes
  localparam logic [1:0]  SEL_NONE     = 2'h0;         // nothing addressed
  localparam logic [1:0]  SEL_BOTH     = 2'h3;         // both, copies only
  // reset values
  localparam logic [7:0]  FACTORY_CODE = 8'h80;        // midscale
  localparam logic [7:0]  ZERO_CODE    = 8'h00;        // wipers before recall
  localparam logic        CS_IDLE      = 1'h1;         // chip select released
  // timing
  localparam int          CLK_NS       = 100;          // 10 MHz system clock
  localparam int          RECALL_NS    = 5000;         // power-up transfer bound
  localparam int          RECALL_CYC   = RECALL_NS / CLK_NS;  // longest, rounds down
  localparam int          BUSY_MS      = 12;           // store_busy_time
  localparam int          BUSY_CYC     = (BUSY_MS * 1000000) / CLK_NS;
  localparam int          SYNC_STAGES  = 2;            // pin synchroniser depth
  // top level sequencing
  typedef enum logic {ST_RECALL, ST_RUN} dwp_state_type;
endpackage : dwp_pkg

// File: pkg/dwp_frame_if.sv
// interface carrying a finished frame from the shifter to the decoder
interface dwp_frame_if;
  logic        valid;  // one-cycle pulse when chip select releases
  logic [15:0] bits;   // last sixteen bits shifted, newest in bit 0
  logic [4:0]  edges;  // clock edges counted in the frame, saturating
  modport src (output valid, output bits, output edges);
  modport dst (input valid, input bits, input edges);
endinterface : dwp_frame_if

// File: hw/dwp_sync.sv
// two flip-flop synchroniser for the serial pins
module dwp_sync
  import dwp_pkg::*;
#(
  parameter int               WIDTH     = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  // refuse widths the logic cannot serve
  if (WIDTH < 1) begin : g_chk
    $error("dwp_sync width must be at least one");
  end

  logic [WIDTH-1:0] meta_q;  // first stage, read only by the second
  logic [WIDTH-1:0] meta_d;  // next first stage
  logic [WIDTH-1:0] safe_q;  // second stage
  logic [WIDTH-1:0] safe_d;  // next second stage

  // next values of both stages
  always_comb
  begin
    meta_d = async_in;
    safe_d = meta_q;
  end

  // register both stages
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= RESET_VAL;
      safe_q <= RESET_VAL;
    end
    else
    begin
      meta_q <= meta_d;
      safe_q <= safe_d;
    end
  end

  assign sync_out = safe_q;
endmodule : dwp_sync

// File: hw/dwp_shifter.sv
// serial shifter: finds clock edges, shifts data, reports frames
module dwp_shifter
  import dwp_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic cs_n_s,   // synchronised chip select
  input  wire logic sclk_s,   // synchronised serial clock
  input  wire logic din_s,    // synchronised serial data
  dwp_frame_if.src  fr
);
  logic              sclk_prev_q, sclk_prev_d;  // clock level one sample ago
  logic              cs_prev_q, cs_prev_d;      // select level one sample ago
  logic [15:0]       shift_q, shift_d;          // shift register
  logic [CNT_W-1:0]  count_q, count_d;          // edges in this frame
  logic              valid_q, valid_d;          // frame pulse
  logic [15:0]       bits_q, bits_d;            // frame bits
  logic [CNT_W-1:0]  edges_q, edges_d;          // frame length
  logic              sclk_rise, cs_rise, cs_fall;

  // edge detection and shifting
  always_comb
  begin
    sclk_rise   = sclk_s & ~sclk_prev_q;
    cs_rise     = cs_n_s & ~cs_prev_q;
    cs_fall     = ~cs_n_s & cs_prev_q;
    sclk_prev_d = sclk_s;
    cs_prev_d   = cs_n_s;
    shift_d     = shift_q;
    count_d     = count_q;
    valid_d     = 1'b0;
    bits_d      = bits_q;
    edges_d     = edges_q;
    if (cs_fall)
    begin
      // new frame starts clean
      shift_d = '0;
      count_d = '0;
    end
    else if (!cs_prev_q && sclk_rise)
    begin
      // an edge seen with the release still counts, since hold may be zero
      shift_d = {shift_q[14:0], din_s};
      if (count_q != EDGES_MAX)
        count_d = count_q + CNT_W'(1);
    end
    if (cs_rise)
    begin
      // hand the frame over; input stays dead until the next fall
      valid_d = 1'b1;
      bits_d  = shift_d;
      edges_d = count_d;
    end
  end

  // register shifter state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sclk_prev_q <= 1'b0;
      cs_prev_q   <= CS_IDLE;
      shift_q     <= '0;
      count_q     <= '0;
      valid_q     <= 1'b0;
      bits_q      <= '0;
      edges_q     <= '0;
    end
    else
    begin
      sclk_prev_q <= sclk_prev_d;
      cs_prev_q   <= cs_prev_d;
      shift_q     <= shift_d;
      count_q     <= count_d;
      valid_q     <= valid_d;
      bits_q      <= bits_d;
      edges_q     <= edges_d;
    end
  end

  assign fr.valid = valid_q;
  assign fr.bits  = bits_q;
  assign fr.edges = edges_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_shift_on_edge: assert property (!cs_prev_q && sclk_rise |=> shift_q[0] == $past(din_s))
    else $error("data bit not shifted on clock edge");
  a_frame_on_release: assert property (cs_rise |=> valid_q ##1 !valid_q)
    else $error("frame not reported once on release");
  a_idle_no_shift: assert property (cs_prev_q && cs_n_s |=> $stable(shift_q))
    else $error("shift register moved while deselected");
endmodule : dwp_shifter

// File: hw/dwp_top.sv
// dual wiper serial command port: pins in, wiper and stored codes out
module dwp_top
  import dwp_pkg::*;
#(
  parameter int BUSY_CYCLES = BUSY_CYC  // store busy span, shorten in simulation
)(
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire logic              CS_N,
  input  wire logic              SCLK,
  input  wire logic              DIN,
  output logic      [CODE_W-1:0] WIPER_TERMINAL_FIRST,
  output logic      [CODE_W-1:0] WIPER_TERMINAL_SECOND,
  output logic      [CODE_W-1:0] STORED_POSITION_A,
  output logic      [CODE_W-1:0] STORED_POSITION_B,
  output logic                   STORE_BUSY,
  output logic                   RECALL_DONE
);
  localparam int BUSY_W = $clog2(BUSY_CYCLES + 1);  // busy counter width
  localparam int RCL_W  = $clog2(RECALL_CYC + 1);   // recall counter width

  // refuse settings the counters cannot serve
  if (BUSY_CYCLES < 1 || RECALL_CYC < 1) begin : g_chk
    $error("dwp_top timing counts must be at least one cycle");
  end

  // select decode, shared by both potentiometers
  function automatic logic dwp_hits(input logic [1:0] sel, input logic pot_b);
    dwp_hits = pot_b ? sel[HDR_SEL_HI] : sel[HDR_SEL_LO];
  endfunction : dwp_hits

  logic [2:0]  pins_s;  // synchronised select, clock, data
  dwp_frame_if fr ();   // frame hand-over

  // every pin passes two flip-flops first
  dwp_sync #(
    .WIDTH     (3),
    .RESET_VAL ({CS_IDLE, 2'b00})
  ) u_sync (
    .clk      (CLK),
    .rst      (RST),
    .async_in ({CS_N, SCLK, DIN}),
    .sync_out (pins_s)
  );

  // shift register and frame detection
  dwp_shifter u_shift (
    .clk    (CLK),
    .rst    (RST),
    .cs_n_s (pins_s[2]),
    .sclk_s (pins_s[1]),
    .din_s  (pins_s[0]),
    .fr     (fr)
  );

  dwp_state_type       state_q, state_d;      // recall or running
  logic [RCL_W-1:0]    rcl_cnt_q, rcl_cnt_d;  // recall cycles spent
  logic [BUSY_W-1:0]   busy_cnt_q, busy_cnt_d;  // store cycles left
  logic [CODE_W-1:0]   wiper_a_q, wiper_a_d;  // wiper_position_a
  logic [CODE_W-1:0]   wiper_b_q, wiper_b_d;  // wiper_position_b
  logic [CODE_W-1:0]   store_a_q, store_a_d;  // stored_position_a
  logic [CODE_W-1:0]   store_b_q, store_b_d;  // stored_position_b
  logic                busy_q, busy_d;        // store in progress
  logic                done_q, done_d;        // recall finished
  logic [7:0]          hdr;                   // header byte
  logic [CODE_W-1:0]   code;                  // wiper_code field
  logic [1:0]          cmd;                   // command bits
  logic [1:0]          sel;                   // select bits
  logic                is_copy;               // copy command
  logic                len_ok;                // frame length fits command
  logic                accept;                // frame will execute
  logic                hit_a, hit_b;          // potentiometer addressed
  logic                store_go;              // stored register written

  // frame decode
  always_comb
  begin
    // long frames carry the header first, code last
    hdr     = (fr.edges == EDGES_LONG) ? fr.bits[15:8] : fr.bits[7:0];
    code    = fr.bits[CODE_W-1:0];
    cmd     = {hdr[HDR_CMD_HI], hdr[HDR_CMD_LO]};
    sel     = {hdr[HDR_SEL_HI], hdr[HDR_SEL_LO]};
    is_copy = cmd[1];
    // writes need sixteen edges, copies eight or sixteen
    if (is_copy)
      len_ok = (fr.edges == EDGES_SHORT) || (fr.edges == EDGES_LONG);
    else
      len_ok = (fr.edges == EDGES_LONG);
    // select 00 drops any frame, both only for copies
    accept  = fr.valid && (state_q == ST_RUN) && len_ok && (sel != SEL_NONE)
              && (is_copy || sel != SEL_BOTH);
    hit_a   = accept && dwp_hits(sel, 1'b0);
    hit_b   = accept && dwp_hits(sel, 1'b1);
  end

  // register updates, recall and busy tracking
  always_comb
  begin
    state_d    = state_q;
    rcl_cnt_d  = rcl_cnt_q;
    busy_cnt_d = busy_cnt_q;
    wiper_a_d  = wiper_a_q;
    wiper_b_d  = wiper_b_q;
    store_a_d  = store_a_q;
    store_b_d  = store_b_q;
    done_d     = done_q;
    store_go   = 1'b0;
    unique case (state_q)
      ST_RECALL:
      begin
        // stored codes move into the wipers while recall runs
        wiper_a_d = store_a_q;
        wiper_b_d = store_b_q;
        if (rcl_cnt_q == RCL_W'(RECALL_CYC - 1))
        begin
          state_d = ST_RUN;
          done_d  = 1'b1;
        end
        else
          rcl_cnt_d = rcl_cnt_q + RCL_W'(1);
      end
      ST_RUN:
      begin
        unique case (cmd)
          CMD_WR_WIPER:
          begin
            // full code is the tap, zero low end to all ones high end
            if (hit_a)
              wiper_a_d = code;
            if (hit_b)
              wiper_b_d = code;
          end
          CMD_WR_STORE:
          begin
            // wipers are left where they are
            if (hit_a)
              store_a_d = code;
            if (hit_b)
              store_b_d = code;
            store_go = hit_a || hit_b;
          end
          CMD_CP_STORE:
          begin
            if (hit_a)
              store_a_d = wiper_a_q;
            if (hit_b)
              store_b_d = wiper_b_q;
            store_go = hit_a || hit_b;
          end
          CMD_CP_WIPER:
          begin
            if (hit_a)
              wiper_a_d = store_a_q;
            if (hit_b)
              wiper_b_d = store_b_q;
          end
        endcase
      end
    endcase
    // a new store restarts the busy span
    if (store_go)
      busy_cnt_d = BUSY_W'(BUSY_CYCLES);
    else if (busy_cnt_q != '0)
      busy_cnt_d = busy_cnt_q - BUSY_W'(1);
    busy_d = (busy_cnt_d != '0);
  end

  // register everything; stored codes reset to midscale
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      state_q    <= ST_RECALL;
      rcl_cnt_q  <= '0;
      busy_cnt_q <= '0;
      wiper_a_q  <= ZERO_CODE;
      wiper_b_q  <= ZERO_CODE;
      store_a_q  <= FACTORY_CODE;
      store_b_q  <= FACTORY_CODE;
      busy_q     <= 1'b0;
      done_q     <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      rcl_cnt_q  <= rcl_cnt_d;
      busy_cnt_q <= busy_cnt_d;
      wiper_a_q  <= wiper_a_d;
      wiper_b_q  <= wiper_b_d;
      store_a_q  <= store_a_d;
      store_b_q  <= store_b_d;
      busy_q     <= busy_d;
      done_q     <= done_d;
    end
  end

  // outputs straight from flip-flops; no serial data path leaves the port
  assign WIPER_TERMINAL_FIRST  = wiper_a_q;
  assign WIPER_TERMINAL_SECOND = wiper_b_q;
  assign STORED_POSITION_A     = store_a_q;
  assign STORED_POSITION_B     = store_b_q;
  assign STORE_BUSY            = busy_q;
  assign RECALL_DONE           = done_q;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  a_wiper_write: assert property (hit_a && cmd == CMD_WR_WIPER
    |=> wiper_a_q == $past(code) && $stable(store_a_q))
    else $error("wiper A write wrong or stored code disturbed");
  a_stored_write: assert property (hit_b && cmd == CMD_WR_STORE
    |=> store_b_q == $past(code) && $stable(wiper_b_q))
    else $error("stored B write wrong or wiper moved");
  a_copy_to_store: assert property (accept && sel == SEL_BOTH && cmd == CMD_CP_STORE
    |=> store_a_q == $past(wiper_a_q) && store_b_q == $past(wiper_b_q))
    else $error("copy to stored registers wrong");
  a_copy_to_wiper: assert property (hit_a && !hit_b && cmd == CMD_CP_WIPER
    |=> wiper_a_q == $past(store_a_q) && $stable(wiper_b_q))
    else $error("copy to wiper A wrong");
  a_bad_length_drop: assert property (fr.valid && !is_copy && fr.edges != EDGES_LONG
    |=> $stable(wiper_a_q) && $stable(store_a_q) && $stable(wiper_b_q))
    else $error("write frame of wrong length executed");
  a_short_copy: assert property (fr.valid && state_q == ST_RUN && fr.edges == EDGES_SHORT
    && fr.bits[5:4] == CMD_CP_WIPER && fr.bits[1:0] == 2'h2
    |=> wiper_b_q == $past(store_b_q))
    else $error("short copy frame not executed");
  a_recall_bound: assert property (state_q == ST_RECALL && rcl_cnt_q == '0
    |-> ##[1:50] done_q)
    else $error("power-up recall too slow");
  a_recall_loads: assert property ($rose(done_q)
    |-> wiper_a_q == store_a_q && wiper_b_q == store_b_q)
    else $error("wipers not loaded from stored codes");
  a_busy_follows: assert property (store_go |=> busy_q [*2])
    else $error("busy not raised after store");

  c_write_wiper: cover property (hit_a && cmd == CMD_WR_WIPER);
  c_copy_both: cover property (accept && sel == SEL_BOTH && cmd == CMD_CP_STORE);
  c_short_copy: cover property (accept && fr.edges == EDGES_SHORT);
  c_recall_done: cover property ($rose(done_q));
endmodule : dwp_top

// File: dv/dwp_ctl_model.sv
// behavioural serial controller that drives frames into the command port
module dwp_ctl_model
  import dwp_pkg::*;
(
  input  wire logic clk,
  output logic      cs_n,
  output logic      sclk,
  output logic      din
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle levels: select released, serial clock parked low
  initial
  begin
    cs_n = CS_IDLE;
    sclk = 1'b0;
    din  = 1'b0;
  end
  // one frame of n edges, msb first, 800 ns serial period
  task automatic send_frame(input logic [15:0] bits, input int n);
    int i;
    @(posedge clk);
    #1 cs_n = 1'b0;
    for (i = 0; i < n; i++)
    begin
      din = bits[15-i];
      repeat (4) @(posedge clk);
      #1 sclk = 1'b1;
      repeat (4) @(posedge clk);
      #1 sclk = 1'b0;
    end
    repeat (2) @(posedge clk);
    #1 cs_n = 1'b1;
    din = ~din;  // released data line shows no stale bit
    repeat (4) @(posedge clk);
  endtask : send_frame
endmodule : dwp_ctl_model

// File: dv/testbench.sv
// self-checking bench for the dual wiper serial command port
module testbench
  import dwp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BUSY_SIM = 20;  // shortened store busy span
  logic              clk;           // system clock
  logic              rst;           // power-up reset
  logic              cs_n;          // chip select from controller
  logic              sclk;          // serial clock from controller
  logic              din;           // serial data from controller
  logic [CODE_W-1:0] wiper_a;       // wiper code a
  logic [CODE_W-1:0] wiper_b;       // wiper code b
  logic [CODE_W-1:0] stored_a;      // stored code a
  logic [CODE_W-1:0] stored_b;      // stored code b
  logic              store_busy;    // store in progress
  logic              recall_done;   // power-up recall finished
  logic [7:0]        exp_wa;        // expected wiper a
  logic [7:0]        exp_wb;        // expected wiper b
  logic [7:0]        exp_sa;        // expected stored a
  logic [7:0]        exp_sb;        // expected stored b
  int                n_errors;      // mismatches seen
  int                total_checks;  // comparisons made
  // free-running 10 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  dwp_top #(.BUSY_CYCLES(BUSY_SIM)) DUT (
    .CLK                   (clk),
    .RST                   (rst),
    .CS_N                  (cs_n),
    .SCLK                  (sclk),
    .DIN                   (din),
    .WIPER_TERMINAL_FIRST  (wiper_a),
    .WIPER_TERMINAL_SECOND (wiper_b),
    .STORED_POSITION_A     (stored_a),
    .STORED_POSITION_B     (stored_b),
    .STORE_BUSY            (store_busy),
    .RECALL_DONE           (recall_done)
  );
  dwp_ctl_model ctl (
    .clk  (clk),
    .cs_n (cs_n),
    .sclk (sclk),
    .din  (din)
  );
  // compare one byte and count it
  task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check8
  // compare all four code outputs with the expectation
  task automatic check_all();
    check8(wiper_a, exp_wa, "wiper a");
    check8(wiper_b, exp_wb, "wiper b");
    check8(stored_a, exp_sa, "stored a");
    check8(stored_b, exp_sb, "stored b");
  endtask : check_all
  // send one frame, update the expectation, then judge the outputs
  task automatic run(input logic [1:0] cmd, input logic [1:0] sel,
                     input logic [7:0] code, input int n);
    logic ok;
    ok = (sel != SEL_NONE) && (cmd[1] ? (n == 8 || n == 16) : (n == 16 && sel != SEL_BOTH));
    ctl.send_frame({2'h0, cmd, 2'h0, sel, code}, n);
    repeat (2) @(posedge clk);
    #1;
    if (ok)
    begin
      case (cmd)
        CMD_WR_WIPER: {exp_wa, exp_wb} = {sel[0] ? code : exp_wa, sel[1] ? code : exp_wb};
        CMD_WR_STORE: {exp_sa, exp_sb} = {sel[0] ? code : exp_sa, sel[1] ? code : exp_sb};
        CMD_CP_STORE: {exp_sa, exp_sb} = {sel[0] ? exp_wa : exp_sa, sel[1] ? exp_wb : exp_sb};
        default:      {exp_wa, exp_wb} = {sel[0] ? exp_sa : exp_wa, sel[1] ? exp_sb : exp_wb};
      endcase
      if (cmd == CMD_WR_STORE || cmd == CMD_CP_STORE)
        check8({7'h00, store_busy}, 8'h01, "busy after store");
    end
    check_all();
  endtask : run
  // reset, then recall of stored codes into the wipers
  task automatic t_power_up();
    int cyc;
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    check8(stored_a, FACTORY_CODE, "stored a in reset");
    check8(stored_b, FACTORY_CODE, "stored b in reset");
    check8({7'h00, recall_done}, 8'h00, "done in reset");
    rst = 1'b0;
    cyc = 0;
    while (recall_done !== 1'b1 && cyc < 200)
    begin
      @(posedge clk);
      #1 cyc++;
    end
    check8((cyc <= RECALL_CYC) ? 8'h01 : 8'h00, 8'h01, "recall time");
    {exp_wa, exp_wb, exp_sa, exp_sb} = {4{FACTORY_CODE}};
    check_all();
    $display("test power_up done");
  endtask : t_power_up
  // direct wiper loads at both ends of the code range
  task automatic t_wiper_writes();
    run(CMD_WR_WIPER, 2'h1, 8'h00, 16);
    run(CMD_WR_WIPER, 2'h2, 8'hFF, 16);
    run(CMD_WR_WIPER, 2'h1, 8'hFF, 16);
    $display("test wiper_writes done");
  endtask : t_wiper_writes
  // stored loads, back to back, wipers must stay put
  task automatic t_store_writes();
    int cyc;
    run(CMD_WR_STORE, 2'h1, 8'h3C, 16);
    run(CMD_WR_STORE, 2'h2, 8'hC3, 16);
    cyc = 0;
    while (store_busy !== 1'b0 && cyc < BUSY_SIM + 10)
    begin
      @(posedge clk);
      #1 cyc++;
    end
    check8({7'h00, store_busy}, 8'h00, "busy released");
    $display("test store_writes done");
  endtask : t_store_writes
  // both copy directions, short and long frames, single and both pots
  task automatic t_copies();
    run(CMD_CP_WIPER, 2'h1, 8'h55, 16);
    run(CMD_WR_WIPER, 2'h1, 8'h96, 16);
    run(CMD_CP_STORE, 2'h3, 8'h00, 8);
    run(CMD_WR_WIPER, 2'h2, 8'h5A, 16);
    run(CMD_WR_WIPER, 2'h1, 8'h01, 16);
    run(CMD_CP_WIPER, 2'h3, 8'hA5, 16);
    run(CMD_WR_WIPER, 2'h2, 8'h77, 16);
    run(CMD_CP_STORE, 2'h2, 8'h00, 16);
    run(CMD_WR_WIPER, 2'h2, 8'h12, 16);
    run(CMD_CP_WIPER, 2'h2, 8'h00, 8);
    $display("test copies done");
  endtask : t_copies
  // one wiper a load, then frames of wrong length or select that must leave everything alone
  task automatic t_refused();
    run(CMD_WR_WIPER, 2'h1, 8'h5C, 16);
    run(CMD_WR_WIPER, 2'h1, 8'hAA, 8);
    run(CMD_WR_STORE, 2'h2, 8'hAA, 12);
    run(CMD_WR_WIPER, 2'h3, 8'hAA, 16);
    run(CMD_CP_STORE, 2'h0, 8'h00, 8);
    run(CMD_CP_WIPER, 2'h1, 8'h00, 12);
    run(CMD_WR_WIPER, 2'h0, 8'h99, 16);
    $display("test refused done");
  endtask : t_refused
  // counts, verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  // hang guard, well beyond the twenty-odd frames of the run
  initial
  begin
    #2000000;
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    report_and_stop();
  end
  // main sequence
  initial
  begin
    rst = 1'b1;
    n_errors = 0;
    total_checks = 0;
    {exp_wa, exp_wb, exp_sa, exp_sb} = {4{FACTORY_CODE}};
    t_power_up();
    t_wiper_writes();
    t_store_writes();
    t_copies();
    t_refused();
    t_power_up();
    report_and_stop();
  end
endmodule : testbench
